// ==== rtl/lockout_timer.sv ====
// Retriggerable timeout counter; expired_out pulses when it runs out.
// Assumes kick and clear come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module lockout_timer #(
  parameter int unsigned COUNT = 80_000_000
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic clear_in,
  input  wire logic kick_in,
  output logic      expired_out
);
  localparam int unsigned W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;
  logic         run_q;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (clear_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (kick_in) begin
      cnt_q <= W'(COUNT - 1);
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  assign expired_out = run_q & (cnt_q == '0) & ~kick_in & ~clear_in;
endmodule // lockout_timer
`default_nettype wire

// ==== rtl/mode_arbiter_pkg.sv ====
// Package of constants for the multi-protocol mode arbiter.
// Assumes a single 20 MHz clock domain.
package mode_arbiter_pkg;
  localparam int unsigned CLK_HZ               = 20_000_000;
  localparam int unsigned LOCKOUT_TIMEOUT_MS   = 4000;
  localparam int unsigned LOCKOUT_TIMEOUT_CYC  = (CLK_HZ / 1000) * LOCKOUT_TIMEOUT_MS;
  localparam logic [7:0]  DEFAULT_ADDRESS      = 8'h03;
  localparam int unsigned EXT_SETUP_AUTODET_OFF_BIT = 4;
  localparam int unsigned BASIC_SETUP_STEPS_BIT     = 5;
  localparam logic [7:0]  TRI_ADDR_MIN         = 8'h01;
  localparam logic [7:0]  TRI_ADDR_MAX         = 8'hff;
  localparam int unsigned TRI_SUB_ADDRS        = 4;
  localparam int unsigned FUNC_KEYS            = 16;
  // Protocol sources, lowest to highest rank index
  localparam logic [2:0]  SRC_NONE             = 3'h0;
  localparam logic [2:0]  SRC_SEL_BUS          = 3'h1;
  localparam logic [2:0]  SRC_DCC              = 3'h2;
  localparam logic [2:0]  SRC_TRINARY          = 3'h3;
  localparam logic [2:0]  SRC_AUTO_REG         = 3'h4;
  localparam logic [2:0]  SRC_DCC_FEEDBACK     = 3'h5;
  typedef enum logic [1:0] {STEPS_14, STEPS_28, STEPS_128} speed_steps_e;
endpackage

// ==== rtl/multi_protocol_mode_arbiter.sv ====
// Mode and protocol arbitration of a multi-protocol locomotive decoder.
// Assumes decoded packet strobes from protocol receivers on ref_clk_in;
// power_fail_in and ac_dir_pulse_in are raw pins and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Factory defaults are address 3 and 14 speed steps.
// - F1 toggles the first aux output, F2 the second.
// - F3 toggles shunting mode, F4 toggles the ramps.
// - DCC supports 14, 28 and 128 speed steps.
// - After power-up detect DCC steps from light-on throttle packets until settled.
// - Detection never reruns until a power interruption.
// - Extended setup byte bit 4 disables auto-detection.
// - Without detection, basic setup byte bit 5 gives the step mode.
// - Trinary F1 to F4 act only in the extended variant.
// - Trinary accepts 14 and 28 step speeds unconfigured.
// - Trinary accepts primary addresses 1 to 255.
// - Trinary answers three further consecutive addresses for more functions.
// - Selective bus drives lights and F1.
// - Own DCC or trinary packet switches the selective-bus receiver off.
// - Selective-bus receiver returns only after power interruption.
// - Auto-registration happens on the track with no configuration.
// - Valid auto-registration packet locks out DCC, trinary and selective bus.
// - Lockout ends at power interruption or about 4 s without such packets.
// - Rank: DCC with feedback, auto-registration, DCC equal trinary, selective bus; here DCC wins over trinary in the same cycle.
// - Each protocol can be disabled by configuration.
// - Analogue enabled and DC load compensation active by default.
// - AC direction pulse reverses direction; only sent when stopped.
module multi_protocol_mode_arbiter
  import mode_arbiter_pkg::*;
#(
  parameter int unsigned LOCKOUT_CYCLES = LOCKOUT_TIMEOUT_CYC
) (
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         power_fail_in,
  input  wire logic [7:0]                   extended_setup_byte_in,
  input  wire logic [7:0]                   basic_setup_byte_in,
  input  wire logic [7:0]                   address_cfg_in,
  input  wire logic                         address_cfg_valid_in,
  input  wire logic [4:0]                   proto_disable_in,
  input  wire logic                         analogue_disable_in,
  input  wire logic                         dcc_pkt_in,
  input  wire logic                         dcc_feedback_in,
  input  wire logic [7:0]                   dcc_addr_in,
  input  wire logic                         dcc_speed_pkt_in,
  input  wire logic [1:0]                   dcc_pkt_steps_in,
  input  wire logic                         dcc_lights_in,
  input  wire logic [FUNC_KEYS-1:0]         dcc_func_in,
  input  wire logic                         tri_pkt_in,
  input  wire logic [7:0]                   tri_addr_in,
  input  wire logic                         tri_extended_in,
  input  wire logic                         tri_28_steps_in,
  input  wire logic                         tri_lights_in,
  input  wire logic [3:0]                   tri_func_in,
  input  wire logic                         sel_pkt_in,
  input  wire logic                         sel_lights_in,
  input  wire logic                         sel_f1_in,
  input  wire logic                         auto_reg_pkt_in,
  input  wire logic                         auto_reg_lights_in,
  input  wire logic [FUNC_KEYS-1:0]         auto_reg_func_in,
  input  wire logic                         analogue_ac_in,
  input  wire logic                         ac_dir_pulse_in,
  output logic [7:0]                        address_out,
  output mode_arbiter_pkg::speed_steps_e    speed_steps_out,
  output logic                              steps_settled_out,
  output logic [2:0]                        active_src_out,
  output logic                              sel_rx_enable_out,
  output logic                              auto_reg_lock_out,
  output logic                              auto_reg_active_out,
  output logic                              lights_out,
  output logic                              first_aux_output_out,
  output logic                              second_aux_output_out,
  output logic                              shunting_mode_out,
  output logic                              ramps_enable_out,
  output logic [FUNC_KEYS-1:0]              functions_out,
  output logic                              analogue_enable_out,
  output logic                              load_comp_out,
  output logic                              direction_out
);
  import mode_arbiter_pkg::*;

  // proto_disable_in bit order
  localparam int unsigned DIS_DCC = 0;
  localparam int unsigned DIS_TRI = 1;
  localparam int unsigned DIS_SEL = 2;
  localparam int unsigned DIS_AUTO = 3;
  localparam int unsigned DIS_ANA_DC_COMP = 4;

  // Synchronised pins and timer
  logic       pf_level;
  logic       pf_rise;
  logic       ac_pulse;
  logic       timer_expired;
  logic       init_pulse;

  // Held state
  logic [7:0] addr_q;
  logic       settled_q;
  speed_steps_e steps_q;
  logic       sel_en_q;
  logic       lock_q;
  logic       lights_q;
  logic [FUNC_KEYS-1:0] func_q;
  logic [FUNC_KEYS-1:0] func_prev_q;
  logic       first_aux_output_q;
  logic       second_aux_output_q;
  logic       shunt_q;
  logic       ramps_q;
  logic       dir_q;
  logic [2:0] src_q;

  // Packet qualification
  logic       dcc_ok;
  logic       dcc_fb_ok;
  logic       tri_ok;
  logic       sel_ok;
  logic       auto_ok;
  logic       dcc_mine;
  logic       tri_mine;
  logic [1:0] tri_sub;
  logic [8:0] tri_off;
  logic [3:0] tri_shift;

  // Same-cycle winner
  logic       take_new;
  logic [2:0] new_src;
  logic       new_lights;
  logic [FUNC_KEYS-1:0] new_func;
  logic [FUNC_KEYS-1:0] new_func_mask;

  power_on_sync u_pf_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (power_fail_in),
    .level_out  (pf_level),
    .rise_out   (pf_rise)
  );

  power_on_sync u_ac_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (ac_dir_pulse_in),
    .level_out  (),
    .rise_out   (ac_pulse)
  );

  // Common power-on initialisation: supply interruption acts as a restart
  assign init_pulse = pf_rise | pf_level;

  // Retriggered by each accepted auto-registration packet
  lockout_timer #(
    .COUNT (LOCKOUT_CYCLES)
  ) u_lock_timer (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .clear_in    (init_pulse),
    .kick_in     (auto_ok),
    .expired_out (timer_expired)
  );

  // Address match; trinary answers base plus three consecutive addresses
  assign dcc_mine = (dcc_addr_in == addr_q);
  assign tri_off  = {1'b0, tri_addr_in} - {1'b0, addr_q};
  assign tri_sub  = tri_off[1:0];
  // Four bits wide so sub-address 3 reaches functions 15:12
  assign tri_shift = {tri_sub, 2'b00};
  assign tri_mine = (tri_addr_in >= TRI_ADDR_MIN) && (tri_addr_in <= TRI_ADDR_MAX)
                    && !tri_off[8] && (tri_off[7:2] == 6'h00);

  // Protocol enables and auto-registration lockout
  // DCC with feedback and auto-registration pass the lockout; the rest wait it out
  assign auto_ok   = auto_reg_pkt_in & ~proto_disable_in[DIS_AUTO];
  assign dcc_fb_ok = dcc_pkt_in & dcc_feedback_in & dcc_mine
                     & ~proto_disable_in[DIS_DCC];
  assign dcc_ok    = dcc_pkt_in & dcc_mine & ~proto_disable_in[DIS_DCC]
                     & (~lock_q | dcc_feedback_in);
  assign tri_ok    = tri_pkt_in & tri_mine & ~proto_disable_in[DIS_TRI]
                     & ~lock_q;
  assign sel_ok    = sel_pkt_in & sel_en_q & ~proto_disable_in[DIS_SEL]
                     & ~lock_q;

  // Fixed priority among same-cycle packets
  always_comb begin
    take_new      = 1'b1;
    new_src       = SRC_NONE;
    new_lights    = lights_q;
    new_func      = func_q;
    new_func_mask = '0;
    if (dcc_fb_ok) begin
      new_src       = SRC_DCC_FEEDBACK;
      new_lights    = dcc_lights_in;
      new_func      = dcc_func_in;
      new_func_mask = '1;
    end else if (auto_ok) begin
      new_src       = SRC_AUTO_REG;
      new_lights    = auto_reg_lights_in;
      new_func      = auto_reg_func_in;
      new_func_mask = '1;
    end else if (dcc_ok) begin
      new_src       = SRC_DCC;
      new_lights    = dcc_lights_in;
      new_func      = dcc_func_in;
      new_func_mask = '1;
    end else if (tri_ok) begin
      new_src = SRC_TRINARY;
      // Only the base address carries the lights
      if (tri_sub == 2'h0) begin
        new_lights = tri_lights_in;
      end
      if (tri_extended_in) begin
        new_func_mask = FUNC_KEYS'(16'h000f) << tri_shift;
        new_func      = FUNC_KEYS'({12'h000, tri_func_in}) << tri_shift;
      end
    end else if (sel_ok) begin
      new_src          = SRC_SEL_BUS;
      new_lights       = sel_lights_in;
      new_func_mask[0] = 1'b1;
      new_func[0]      = sel_f1_in;
    end else begin
      take_new = 1'b0;
    end
  end

  // Own address, reloaded from configuration
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q <= DEFAULT_ADDRESS;
    end else if (address_cfg_valid_in) begin
      addr_q <= address_cfg_in;
    end
  end

  // Speed step detection, once per power-up
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      steps_q   <= STEPS_14;
      settled_q <= 1'b0;
    end else if (init_pulse) begin
      settled_q <= 1'b0;
    end else if (extended_setup_byte_in[EXT_SETUP_AUTODET_OFF_BIT]) begin
      steps_q   <= basic_setup_byte_in[BASIC_SETUP_STEPS_BIT] ? STEPS_28 : STEPS_14;
      settled_q <= 1'b1;
    end else if (!settled_q && dcc_ok && dcc_speed_pkt_in && dcc_lights_in) begin
      case (dcc_pkt_steps_in)
        2'h0:    steps_q <= STEPS_14;
        2'h1:    steps_q <= STEPS_28;
        2'h2:    steps_q <= STEPS_128;
        default: steps_q <= steps_q;
      endcase
      // A 14-step packet settles only once it agrees with the held mode
      settled_q <= (dcc_pkt_steps_in != 2'h0) || (steps_q == STEPS_14);
    end
  end

  // Selective-bus receiver shutoff
  // An own packet beside power return still switches it off
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_en_q <= 1'b1;
    end else if (dcc_ok || tri_ok) begin
      sel_en_q <= 1'b0;
    end else if (init_pulse) begin
      sel_en_q <= 1'b1;
    end
  end

  // Auto-registration lockout; a fresh packet wins over the timeout
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (init_pulse) begin
      lock_q <= 1'b0;
    end else if (auto_ok) begin
      lock_q <= 1'b1;
    end else if (timer_expired) begin
      lock_q <= 1'b0;
    end
  end

  // Packet results; func_prev_q keeps the keys of the cycle before
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_q       <= SRC_NONE;
      lights_q    <= 1'b0;
      func_q      <= '0;
      func_prev_q <= '0;
    end else if (take_new) begin
      src_q       <= new_src;
      lights_q    <= new_lights;
      func_q      <= (func_q & ~new_func_mask) | (new_func & new_func_mask);
      func_prev_q <= func_q;
    end else begin
      func_prev_q <= func_q;
    end
  end

  // Default key mapping: rising key state toggles each target
  // Edge, not level, so a held key toggles once
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_aux_output_q  <= 1'b0;
      second_aux_output_q  <= 1'b0;
      shunt_q <= 1'b0;
      ramps_q <= 1'b1;
    end else begin
      first_aux_output_q  <= first_aux_output_q  ^ (func_q[0] & ~func_prev_q[0]);
      second_aux_output_q  <= second_aux_output_q  ^ (func_q[1] & ~func_prev_q[1]);
      shunt_q <= shunt_q ^ (func_q[2] & ~func_prev_q[2]);
      ramps_q <= ramps_q ^ (func_q[3] & ~func_prev_q[3]);
    end
  end

  // AC direction relay replacement; station only pulses while stopped
  // Pulse edge only, so a long pulse reverses once
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_q <= 1'b0;
    end else if (analogue_ac_in && !analogue_disable_in && ac_pulse) begin
      dir_q <= ~dir_q;
    end
  end

  // Outputs straight from state or configuration
  assign address_out           = addr_q;
  assign speed_steps_out       = steps_q;
  assign steps_settled_out     = settled_q;
  assign active_src_out        = src_q;
  assign sel_rx_enable_out     = sel_en_q;
  assign auto_reg_lock_out     = lock_q;
  assign auto_reg_active_out   = lock_q & ~proto_disable_in[DIS_AUTO];
  assign lights_out            = lights_q;
  assign first_aux_output_out  = first_aux_output_q;
  assign second_aux_output_out = second_aux_output_q;
  assign shunting_mode_out     = shunt_q;
  assign ramps_enable_out      = ramps_q;
  assign functions_out         = func_q;
  assign analogue_enable_out   = ~analogue_disable_in;
  assign load_comp_out         = ~analogue_disable_in & ~proto_disable_in[DIS_ANA_DC_COMP];
  assign direction_out         = dir_q;
  // tri_28_steps_in needs no state: it only drives unused_tri and reaches no output
  logic unused_tri;
  assign unused_tri = tri_28_steps_in;
endmodule // multi_protocol_mode_arbiter
`default_nettype wire

// ==== rtl/power_on_sync.sv ====
// Two-flop synchroniser with rising-edge pulse output.
// Assumes input arrives from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module power_on_sync (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
endmodule // power_on_sync
`default_nettype wire

// ==== tb/multi_protocol_mode_arbiter_chk.sv ====
// Port-level assertions of the mode arbiter.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module multi_protocol_mode_arbiter_chk #(
  parameter int unsigned LOCKOUT_CYCLES = 50
) (
  input wire logic                                ref_clk_in,
  input wire logic                                rst_in,
  input wire logic                                power_fail_in,
  input wire logic [7:0]                          extended_setup_byte_in,
  input wire logic [4:0]                          proto_disable_in,
  input wire logic                                analogue_disable_in,
  input wire logic                                dcc_pkt_in,
  input wire logic                                dcc_feedback_in,
  input wire logic [7:0]                          dcc_addr_in,
  input wire logic                                dcc_speed_pkt_in,
  input wire logic [1:0]                          dcc_pkt_steps_in,
  input wire logic                                dcc_lights_in,
  input wire logic                                auto_reg_pkt_in,
  input wire logic [7:0]                          address_out,
  input wire mode_arbiter_pkg::speed_steps_e      speed_steps_out,
  input wire logic                                steps_settled_out,
  input wire logic                                sel_rx_enable_out,
  input wire logic                                auto_reg_lock_out,
  input wire logic [mode_arbiter_pkg::FUNC_KEYS-1:0] functions_out,
  input wire logic                                first_aux_output_out,
  input wire logic                                shunting_mode_out,
  input wire logic                                analogue_enable_out
);
  import mode_arbiter_pkg::*;
  int unsigned idle_q;
  logic        own_dcc;
  assign own_dcc = dcc_pkt_in && dcc_addr_in == address_out && !proto_disable_in[0];
  // Cycles of lockout since the last auto-registration packet
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_q <= '0;
    end else if (!auto_reg_lock_out || auto_reg_pkt_in) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_reset_defaults: assert property ($fell(rst_in) |-> address_out == DEFAULT_ADDRESS
    && speed_steps_out == STEPS_14) else $error("reset defaults wrong");
  a_detect_steps: assert property ((!power_fail_in)[*4] ##0 own_dcc
    && !auto_reg_lock_out && dcc_speed_pkt_in && dcc_lights_in && dcc_pkt_steps_in != 2'h0
    && !steps_settled_out && !extended_setup_byte_in[4] |=> steps_settled_out
    && speed_steps_out == $past(dcc_pkt_steps_in)) else $error("step detection wrong");
  a_settled_hold: assert property ((!power_fail_in)[*4] ##0 steps_settled_out
    && !extended_setup_byte_in[4] |=> steps_settled_out && $stable(speed_steps_out))
    else $error("detection reran");
  a_sel_off: assert property (own_dcc && (!auto_reg_lock_out || dcc_feedback_in)
    |=> !sel_rx_enable_out) else $error("sel receiver stayed on");
  a_sel_stays_off: assert property ((!power_fail_in)[*4] ##0 !sel_rx_enable_out
    |=> !sel_rx_enable_out) else $error("sel receiver back without power loss");
  a_lock_set: assert property ((!power_fail_in)[*4] ##0 auto_reg_pkt_in
    && !proto_disable_in[3] |=> auto_reg_lock_out) else $error("lock not set");
  a_lock_blocks: assert property (auto_reg_lock_out && dcc_pkt_in && !dcc_feedback_in
    && !auto_reg_pkt_in |=> $stable(functions_out)) else $error("dcc passed lock");
  a_lock_bound: assert property (auto_reg_lock_out |-> idle_q <= LOCKOUT_CYCLES + 2)
    else $error("lock outlived timeout");
  a_aux_toggle: assert property ($rose(functions_out[0])
    |=> first_aux_output_out != $past(first_aux_output_out)) else $error("aux not toggled");
  a_shunt_toggle: assert property ($rose(functions_out[2])
    |=> shunting_mode_out != $past(shunting_mode_out)) else $error("shunt not toggled");
  a_analogue_en: assert property (analogue_enable_out == !analogue_disable_in)
    else $error("analogue enable wrong");
endmodule // multi_protocol_mode_arbiter_chk
bind multi_protocol_mode_arbiter multi_protocol_mode_arbiter_chk #(
  .LOCKOUT_CYCLES(LOCKOUT_CYCLES)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .power_fail_in(power_fail_in),
  .extended_setup_byte_in(extended_setup_byte_in), .proto_disable_in(proto_disable_in),
  .analogue_disable_in(analogue_disable_in), .dcc_pkt_in(dcc_pkt_in),
  .dcc_feedback_in(dcc_feedback_in), .dcc_addr_in(dcc_addr_in),
  .dcc_speed_pkt_in(dcc_speed_pkt_in), .dcc_pkt_steps_in(dcc_pkt_steps_in),
  .dcc_lights_in(dcc_lights_in), .auto_reg_pkt_in(auto_reg_pkt_in),
  .address_out(address_out), .speed_steps_out(speed_steps_out),
  .steps_settled_out(steps_settled_out), .sel_rx_enable_out(sel_rx_enable_out),
  .auto_reg_lock_out(auto_reg_lock_out), .functions_out(functions_out),
  .first_aux_output_out(first_aux_output_out), .shunting_mode_out(shunting_mode_out),
  .analogue_enable_out(analogue_enable_out));
`default_nettype wire

// ==== tb/multi_protocol_mode_arbiter_tb.sv ====
// Self-checking bench of the multi-protocol mode arbiter.
// Assumes the station model for packet strobes and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module multi_protocol_mode_arbiter_tb;
  import mode_arbiter_pkg::*;
  localparam int unsigned LK = 50;
  logic         clk, rst, pf, av, adis, fb, spd, dl, text, t28, tl, sl, sf1, al, ac;
  logic         cmd_v, stopped, dpk, tpk, spk, apk, dirp;
  logic         settled, selrx, lock, aact, lights, first_aux_output, second_aux_output, shunt, ramps, aen, lcomp, dir;
  logic [2:0]   cmd_k, src;
  logic [1:0]   dsteps;
  logic [3:0]   tfunc, keep;
  logic [4:0]   pdis;
  logic [7:0]   ext, basic, acfg, daddr, taddr, addr_o;
  logic [15:0]  dfunc, afunc, func_o, last;
  speed_steps_e steps_o;
  int           fails, cmp_count, seed, n, i;
  station_model u_station (.ref_clk_in(clk), .rst_in(rst), .cmd_valid_in(cmd_v),
    .cmd_kind_in(cmd_k), .stopped_in(stopped), .dcc_pkt_out(dpk), .tri_pkt_out(tpk),
    .sel_pkt_out(spk), .auto_pkt_out(apk), .dir_pulse_out(dirp));
  multi_protocol_mode_arbiter #(.LOCKOUT_CYCLES(LK)) dut (
    .ref_clk_in(clk), .rst_in(rst), .power_fail_in(pf), .extended_setup_byte_in(ext),
    .basic_setup_byte_in(basic), .address_cfg_in(acfg), .address_cfg_valid_in(av),
    .proto_disable_in(pdis), .analogue_disable_in(adis), .dcc_pkt_in(dpk),
    .dcc_feedback_in(fb), .dcc_addr_in(daddr), .dcc_speed_pkt_in(spd),
    .dcc_pkt_steps_in(dsteps), .dcc_lights_in(dl), .dcc_func_in(dfunc), .tri_pkt_in(tpk),
    .tri_addr_in(taddr), .tri_extended_in(text), .tri_28_steps_in(t28),
    .tri_lights_in(tl), .tri_func_in(tfunc), .sel_pkt_in(spk), .sel_lights_in(sl),
    .sel_f1_in(sf1), .auto_reg_pkt_in(apk), .auto_reg_lights_in(al),
    .auto_reg_func_in(afunc), .analogue_ac_in(ac), .ac_dir_pulse_in(dirp),
    .address_out(addr_o), .speed_steps_out(steps_o), .steps_settled_out(settled),
    .active_src_out(src), .sel_rx_enable_out(selrx), .auto_reg_lock_out(lock),
    .auto_reg_active_out(aact), .lights_out(lights), .first_aux_output_out(first_aux_output),
    .second_aux_output_out(second_aux_output), .shunting_mode_out(shunt), .ramps_enable_out(ramps),
    .functions_out(func_o), .analogue_enable_out(aen), .load_comp_out(lcomp),
    .direction_out(dir));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One packet from the station, then time for state and toggles to land
  task automatic send(input logic [2:0] k);
    cmd_v <= 1'b1;
    cmd_k <= k;
    tick(1);
    cmd_v <= 1'b0;
    tick(3);
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    seed = 21747;
    rst = 1'b1;
    {pf, av, adis, fb, spd, dl, text, t28, tl, sl, sf1, al, ac, cmd_v, stopped} = '0;
    {cmd_k, dsteps, tfunc, pdis, ext, basic, acfg, taddr, dfunc, afunc} = '0;
    daddr = 8'h03;
    tick(20);
    rst <= 1'b0;
    tick(2);
    chk(addr_o, 8'h03);
    chk(steps_o, STEPS_14);
    chk({selrx, ramps, aen, lcomp}, 4'hf);
    sl <= 1'b1;
    sf1 <= 1'b1;
    send(3'h2);
    chk({lights, func_o[0], first_aux_output}, 3'h7);
    spd <= 1'b1;
    dl <= 1'b1;
    dsteps <= 2'h2;
    dfunc <= 16'h000d;
    send(3'h0);
    chk(steps_o, STEPS_128);
    chk({settled, selrx, shunt, ramps, first_aux_output}, 5'h15);
    dsteps <= 2'h1;
    dfunc <= 16'h000f;
    send(3'h0);
    chk({settled, steps_o, second_aux_output}, {1'b1, STEPS_128, 1'b1});
    sl <= 1'b0;
    send(3'h2);
    chk(lights, 1'b1);
    spd <= 1'b0;
    for (i = 0; i < 8; i++) begin
      last = 16'($random(seed));
      dfunc <= last;
      dl <= last[15];
      send(3'h0);
      chk({lights, func_o}, {last[15], last});
    end
    pdis <= 5'h11;
    dfunc <= ~last;
    send(3'h0);
    chk({lcomp, func_o}, {1'b0, last});
    pdis <= 5'h00;
    afunc <= 16'h00f0;
    send(3'h3);
    chk({lock, func_o}, {1'b1, 16'h00f0});
    chk(aact, 1'b1);
    dfunc <= 16'h0001;
    send(3'h0);
    chk(func_o, 16'h00f0);
    fb <= 1'b1;
    dfunc <= 16'h0003;
    send(3'h0);
    fb <= 1'b0;
    chk(func_o, 16'h0003);
    n = 0;
    while (lock === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk(n > LK - 16 && n <= LK, 1'b1);
    send(3'h3);
    pf <= 1'b1;
    tick(6);
    pf <= 1'b0;
    tick(6);
    chk({selrx, settled, lock}, 3'h4);
    spd <= 1'b1;
    dl <= 1'b1;
    dsteps <= 2'h0;
    send(3'h0);
    send(3'h0);
    chk({settled, steps_o}, {1'b1, STEPS_14});
    ext <= 8'h10;
    basic <= 8'h20;
    tick(4);
    chk(steps_o, STEPS_28);
    spd <= 1'b1;
    dsteps <= 2'h2;
    send(3'h0);
    chk(steps_o, STEPS_28);
    acfg <= 8'hc8;
    av <= 1'b1;
    tick(1);
    av <= 1'b0;
    tick(2);
    chk(addr_o, 8'hc8);
    taddr <= 8'hca;
    text <= 1'b1;
    tfunc <= 4'ha;
    send(3'h1);
    chk(func_o[11:8], 4'ha);
    keep = func_o[3:0];
    taddr <= 8'hc8;
    text <= 1'b0;
    tfunc <= ~keep;
    send(3'h1);
    chk(func_o[3:0], keep);
    taddr <= 8'hc9;
    text <= 1'b1;
    t28 <= 1'b1;
    tfunc <= 4'h6;
    send(3'h1);
    chk({src, func_o[7:4]}, {SRC_TRINARY, 4'h6});
    ac <= 1'b1;
    stopped <= 1'b1;
    send(3'h4);
    tick(4);
    chk(dir, 1'b1);
    end_sim();
  end
endmodule // multi_protocol_mode_arbiter_tb
`default_nettype wire

// ==== tb/station_model.sv ====
// Track station model: turns bench commands into one-cycle packet strobes.
// Assumes commands change just after a rising edge of ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module station_model (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [2:0] cmd_kind_in,
  input  wire logic       stopped_in,
  output logic            dcc_pkt_out,
  output logic            tri_pkt_out,
  output logic            sel_pkt_out,
  output logic            auto_pkt_out,
  output logic            dir_pulse_out
);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {dcc_pkt_out, tri_pkt_out, sel_pkt_out, auto_pkt_out, dir_pulse_out} <= 5'h00;
    end else begin
      dcc_pkt_out   <= cmd_valid_in && cmd_kind_in == 3'h0;
      tri_pkt_out   <= cmd_valid_in && cmd_kind_in == 3'h1;
      sel_pkt_out   <= cmd_valid_in && cmd_kind_in == 3'h2;
      auto_pkt_out  <= cmd_valid_in && cmd_kind_in == 3'h3;
      // Direction pulse goes only to a stopped locomotive
      dir_pulse_out <= cmd_valid_in && cmd_kind_in == 3'h4 && stopped_in;
    end
  end
endmodule // station_model
`default_nettype wire
